// ===== hw/pvc_pkg.sv
// Package of register offsets, fields and timing constants for the PLL VCO calibration control
// What this block does
// - Reference select bit clear picks crystal input; set disables that option.
// - Pump current code bits 3..0, current is (code+1) times 300 uA.
// - Bleed current code is 8 bits, current is code times 3.75 uA.
// - Lock status bit 0 reads one while digital lock detect declares lock.
// - Output pin carries lock detect when enabled and selector equals one.
// - Writing integer low register launches VCO autocalibration.
// - Calibration runs settle timeout, band selection, then loop settling.
// - Settle wait is coarse times 1024 plus fine PHASE_FREQUENCY_DETECTOR cycles.
// - Coarse timeout in 0x218[4:0]; fine split 0x21C[7:0], 0x21D[1:0].
// - Band clock is PHASE_FREQUENCY_DETECTOR clock divided by 8-bit divisor 1..255.
// - Each band step takes 16 band clocks; a search has 11 steps.
// - Chosen band readable in 0x248 bits 7..1 after lock.
// - Pump current setting takes effect on integer low write; band clock divisor applies at once.
package pvc_pkg;
  localparam logic [11:0] ADDR_MUX_EN = 12'h120;
  localparam logic [11:0] ADDR_REF_MODE = 12'h129;
  localparam logic [11:0] ADDR_INT_LOW = 12'h200;
  localparam logic [11:0] ADDR_LOCK_WIN = 12'h214;
  localparam logic [11:0] ADDR_TO_COARSE = 12'h218;
  localparam logic [11:0] ADDR_TO_FINE_LO = 12'h21c;
  localparam logic [11:0] ADDR_TO_FINE_HI = 12'h21d;
  localparam logic [11:0] ADDR_BAND_DIV = 12'h21e;
  localparam logic [11:0] ADDR_BLEED_CTL = 12'h22d;
  localparam logic [11:0] ADDR_PUMP_CODE = 12'h22e;
  localparam logic [11:0] ADDR_BLEED_CODE = 12'h22f;
  localparam logic [11:0] ADDR_BAND_RB = 12'h248;
  localparam logic [11:0] ADDR_LOCK_STAT = 12'h24d;
  localparam logic [11:0] ADDR_MUX_OUTPUT_SELECT = 12'h24e;
  localparam int MUX_EN_BIT = 7;
  localparam int REF_SEL_BIT = 1;
  localparam int BLEED_EN_BIT = 0;
  localparam int LOCK_BIT = 0;
  localparam logic [7:0] MUX_OUTPUT_SELECT_LOCK = 8'h01;
  localparam logic [7:0] RST_MUX_EN = 8'h00;
  localparam logic [7:0] RST_REF_MODE = 8'h00;
  localparam logic [7:0] RST_INT_LOW = 8'h00;
  localparam logic [7:0] RST_LOCK_WIN = 8'h00;
  localparam logic [7:0] RST_TO_COARSE = 8'h02;
  localparam logic [7:0] RST_TO_FINE_LO = 8'h02;
  localparam logic [7:0] RST_TO_FINE_HI = 8'h00;
  localparam logic [7:0] RST_BAND_DIV = 8'h01;
  localparam logic [7:0] RST_BLEED_CTL = 8'h00;
  localparam logic [7:0] RST_PUMP_CODE = 8'h04;
  localparam logic [7:0] RST_BLEED_CODE = 8'h04;
  localparam logic [7:0] RST_MUX_OUTPUT_SELECT = 8'h00;
  localparam int COARSE_SHIFT = 10;
  localparam logic [4:0] STEP_CLOCKS = 5'h10;
  localparam logic [3:0] BAND_STEPS = 4'hb;
  localparam int BAND_W = 7;
  localparam logic [15:0] LOOP_SETTLE_CYC = 16'h0100;
endpackage

// ===== hw/pvc_band_clock.sv
// Divider producing the band selection clock tick from the PHASE_FREQUENCY_DETECTOR clock
`timescale 1ns/1ps
module pvc_band_clock (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Control
  input wire logic run,
  input wire logic [7:0] divisor,
  // Tick
  output logic tick
);
  logic [7:0] cnt_r;
  logic [7:0] lim;

  // Divisor zero treated as one
  assign lim = (divisor == 8'h00) ? 8'h01 : divisor;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= 8'h00;
      tick <= 1'b0;
    end else if (!run) begin
      cnt_r <= 8'h00;
      tick <= 1'b0;
    end else if (cnt_r + 8'h01 >= lim) begin
      cnt_r <= 8'h00;
      tick <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 8'h01;
      tick <= 1'b0;
    end
  end

  tick_spacing_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    tick && run && $stable(divisor) && divisor > 8'h01 |=> !tick)
    else $error("band tick too frequent");
endmodule

// ===== hw/pvc_settle_timer.sv
// Settle timeout counter: coarse times 1024 plus fine PHASE_FREQUENCY_DETECTOR cycles
`timescale 1ns/1ps
module pvc_settle_timer (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Control
  input wire logic start,
  input wire logic [4:0] coarse,
  input wire logic [9:0] fine,
  // Status
  output logic done
);
  logic [15:0] left_r;
  logic busy_r;
  logic [15:0] total;
  logic [15:0] elapsed_r;
  logic [15:0] want_r;

  assign total = {1'b0, coarse, 10'h000} + {6'h00, fine};

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      left_r <= 16'h0000;
      busy_r <= 1'b0;
      done <= 1'b0;
    end else if (start) begin
      left_r <= (total == 16'h0000) ? 16'h0001 : total;
      busy_r <= 1'b1;
      done <= 1'b0;
    end else if (busy_r && left_r == 16'h0001) begin
      left_r <= 16'h0000;
      busy_r <= 1'b0;
      done <= 1'b1;
    end else begin
      left_r <= busy_r ? left_r - 16'h0001 : left_r;
      done <= 1'b0;
    end
  end

  // Separate cycle count since start, used only by the length check
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      elapsed_r <= 16'h0000;
      want_r <= 16'h0000;
    end else if (start) begin
      elapsed_r <= 16'h0000;
      want_r <= (total == 16'h0000) ? 16'h0001 : total;
    end else begin
      elapsed_r <= elapsed_r + 16'h0001;
    end
  end

  settle_len_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    done |-> elapsed_r == want_r)
    else $error("settle length wrong");
endmodule

// ===== hw/pvc_top.sv
// Register file, lock routing and VCO autocalibration sequencer
`timescale 1ns/1ps
module pvc_top (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Register port
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [11:0] regAddr,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  // Analog side
  input wire logic lockDetect,
  input wire logic [6:0] bandCompare,
  output logic [3:0] pumpCurrentCode,
  output logic [7:0] bleedCurrentCode,
  output logic bleedEnable,
  output logic refBufferModeSel,
  output logic [1:0] lockWindowBias,
  output logic [1:0] lockWindowPrecision,
  // Calibration status
  output logic calBusy,
  output logic [6:0] bandTrial,
  // Multiplexed output pin
  output logic multiplexedOutputPin
);
  typedef enum logic [1:0] {CAL_IDLE, CAL_SETTLE, CAL_BAND, CAL_LOOP} pvc_cal_e;

  // ------------------------------------------------------------
  // Register file
  // ------------------------------------------------------------
  logic [7:0] muxEn_r, refMode_r, lockWin_r, toCoarse_r, toFineLo_r, toFineHi_r;
  logic [7:0] bandDiv_r, bleedCtl_r, pumpShadow_r, bleedCode_r, muxSel_r;
  logic [3:0] pumpActive_r;
  logic [6:0] band_r;
  logic intLowWr;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] b);
    return a == b;
  endfunction

  assign intLowWr = regWrite && hit(regAddr, pvc_pkg::ADDR_INT_LOW);

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      muxEn_r <= pvc_pkg::RST_MUX_EN;
      refMode_r <= pvc_pkg::RST_REF_MODE;
      lockWin_r <= pvc_pkg::RST_LOCK_WIN;
      toCoarse_r <= pvc_pkg::RST_TO_COARSE;
      toFineLo_r <= pvc_pkg::RST_TO_FINE_LO;
      toFineHi_r <= pvc_pkg::RST_TO_FINE_HI;
      bandDiv_r <= pvc_pkg::RST_BAND_DIV;
      bleedCtl_r <= pvc_pkg::RST_BLEED_CTL;
      pumpShadow_r <= pvc_pkg::RST_PUMP_CODE;
      bleedCode_r <= pvc_pkg::RST_BLEED_CODE;
      muxSel_r <= pvc_pkg::RST_MUX_OUTPUT_SELECT;
    end else if (regWrite) begin
      unique case (regAddr)
        pvc_pkg::ADDR_MUX_EN: muxEn_r <= regWdata;
        pvc_pkg::ADDR_REF_MODE: refMode_r <= regWdata;
        pvc_pkg::ADDR_LOCK_WIN: lockWin_r <= regWdata;
        pvc_pkg::ADDR_TO_COARSE: toCoarse_r <= regWdata;
        pvc_pkg::ADDR_TO_FINE_LO: toFineLo_r <= regWdata;
        pvc_pkg::ADDR_TO_FINE_HI: toFineHi_r <= regWdata;
        pvc_pkg::ADDR_BAND_DIV: bandDiv_r <= regWdata;
        pvc_pkg::ADDR_BLEED_CTL: bleedCtl_r <= regWdata;
        pvc_pkg::ADDR_PUMP_CODE: pumpShadow_r <= regWdata;
        pvc_pkg::ADDR_BLEED_CODE: bleedCode_r <= regWdata;
        pvc_pkg::ADDR_MUX_OUTPUT_SELECT: muxSel_r <= regWdata;
        default: ;
      endcase
    end
  end

  // Pump current shadow applied only by the integer low write
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pumpActive_r <= pvc_pkg::RST_PUMP_CODE[3:0];
    end else if (intLowWr) begin
      pumpActive_r <= pumpShadow_r[3:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      regRdata <= 8'h00;
    end else if (regRead) begin
      unique case (regAddr)
        pvc_pkg::ADDR_MUX_EN: regRdata <= muxEn_r;
        pvc_pkg::ADDR_REF_MODE: regRdata <= refMode_r;
        pvc_pkg::ADDR_LOCK_WIN: regRdata <= lockWin_r;
        pvc_pkg::ADDR_TO_COARSE: regRdata <= toCoarse_r;
        pvc_pkg::ADDR_TO_FINE_LO: regRdata <= toFineLo_r;
        pvc_pkg::ADDR_TO_FINE_HI: regRdata <= toFineHi_r;
        pvc_pkg::ADDR_BAND_DIV: regRdata <= bandDiv_r;
        pvc_pkg::ADDR_BLEED_CTL: regRdata <= bleedCtl_r;
        pvc_pkg::ADDR_PUMP_CODE: regRdata <= pumpShadow_r;
        pvc_pkg::ADDR_BLEED_CODE: regRdata <= bleedCode_r;
        pvc_pkg::ADDR_MUX_OUTPUT_SELECT: regRdata <= muxSel_r;
        pvc_pkg::ADDR_BAND_RB: regRdata <= {band_r, 1'b0};
        pvc_pkg::ADDR_LOCK_STAT: regRdata <= {7'h00, lockDetect};
        default: regRdata <= 8'h00;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Analog controls and output pin
  // ------------------------------------------------------------
  assign pumpCurrentCode = pumpActive_r;
  assign bleedCurrentCode = bleedCode_r;
  assign bleedEnable = bleedCtl_r[pvc_pkg::BLEED_EN_BIT];
  assign refBufferModeSel = refMode_r[pvc_pkg::REF_SEL_BIT];
  assign lockWindowBias = lockWin_r[1:0];
  assign lockWindowPrecision = lockWin_r[3:2];

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      multiplexedOutputPin <= 1'b0;
    end else begin
      multiplexedOutputPin <= muxEn_r[pvc_pkg::MUX_EN_BIT]
        && muxSel_r == pvc_pkg::MUX_OUTPUT_SELECT_LOCK && lockDetect;
    end
  end

  // ------------------------------------------------------------
  // Calibration sequencer
  // ------------------------------------------------------------
  pvc_cal_e state_r;
  logic settleDone, bandTick;
  logic [4:0] stepClk_r;
  logic [3:0] step_r;
  logic [15:0] loopCnt_r;

  pvc_settle_timer settle_timer (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .start(intLowWr),
    .coarse(toCoarse_r[4:0]),
    .fine({toFineHi_r[1:0], toFineLo_r}),
    .done(settleDone)
  );

  pvc_band_clock band_clock (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .run(state_r == CAL_BAND),
    .divisor(bandDiv_r),
    .tick(bandTick)
  );

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= CAL_IDLE;
      stepClk_r <= 5'h00;
      step_r <= 4'h0;
      loopCnt_r <= 16'h0000;
      band_r <= 7'h00;
      bandTrial <= 7'h00;
    end else if (intLowWr) begin
      state_r <= CAL_SETTLE;
      stepClk_r <= 5'h00;
      step_r <= 4'h0;
    end else begin
      unique case (state_r)
        CAL_IDLE: ;
        CAL_SETTLE: begin
          if (settleDone) begin
            state_r <= CAL_BAND;
            bandTrial <= 7'h40;
          end
        end
        CAL_BAND: begin
          if (bandTick) begin
            if (stepClk_r == pvc_pkg::STEP_CLOCKS - 5'h01) begin
              stepClk_r <= 5'h00;
              step_r <= step_r + 4'h1;
              if (step_r < 4'h7) begin
                bandTrial <= bandCompare;
              end
              if (step_r == pvc_pkg::BAND_STEPS - 4'h1) begin
                band_r <= bandTrial;
                state_r <= CAL_LOOP;
                loopCnt_r <= pvc_pkg::LOOP_SETTLE_CYC;
              end
            end else begin
              stepClk_r <= stepClk_r + 5'h01;
            end
          end
        end
        CAL_LOOP: begin
          loopCnt_r <= loopCnt_r - 16'h0001;
          if (loopCnt_r == 16'h0001) begin
            state_r <= CAL_IDLE;
          end
        end
      endcase
    end
  end

  assign calBusy = state_r != CAL_IDLE;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  launch_cal_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    intLowWr |=> state_r == CAL_SETTLE)
    else $error("integer low write did not launch calibration");
  restart_cal_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    intLowWr && state_r != CAL_IDLE |=> state_r == CAL_SETTLE && step_r == 4'h0)
    else $error("calibration not restarted");
  phase_order_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    state_r == CAL_BAND && !intLowWr |=> state_r inside {CAL_BAND, CAL_LOOP})
    else $error("band phase left wrongly");
  settle_to_band_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    state_r == CAL_SETTLE && settleDone && !intLowWr |=> state_r == CAL_BAND)
    else $error("settle did not advance");
  step_count_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    state_r == CAL_BAND |-> step_r < pvc_pkg::BAND_STEPS)
    else $error("too many band steps");
  pump_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !intLowWr |=> $stable(pumpCurrentCode))
    else $error("pump code changed without integer write");
  lock_read_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    regRead && regAddr == pvc_pkg::ADDR_LOCK_STAT |=> regRdata == {7'h00, $past(lockDetect)})
    else $error("lock status readback wrong");
  mux_pin_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    multiplexedOutputPin |-> $past(lockDetect) && $past(muxSel_r) == 8'h01)
    else $error("output pin without lock selection");
  band_rb_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    regRead && regAddr == pvc_pkg::ADDR_BAND_RB |=> regRdata[0] == 1'b0)
    else $error("band readback low bit set");
  bleed_map_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    regWrite && regAddr == pvc_pkg::ADDR_BLEED_CODE |=> bleedCurrentCode == $past(regWdata))
    else $error("bleed code not applied");

  cal_done_c: cover property (@(posedge ref_clk) disable iff (!rst_b)
    state_r == CAL_LOOP ##1 state_r == CAL_IDLE);
  restart_c: cover property (@(posedge ref_clk) disable iff (!rst_b)
    state_r == CAL_SETTLE && intLowWr);
  pin_c: cover property (@(posedge ref_clk) disable iff (!rst_b) multiplexedOutputPin);
endmodule

// ===== tb/tb_pll_vco_calibration_control.sv
// Self-checking bench for the PLL VCO calibration control block
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin nCompared++; if ((got) !== (exp)) begin errorCnt++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, exp, got); end end
module tb_pll_vco_calibration_control;
  // ----------------------------------------
  // Signals and model state
  // ----------------------------------------
  localparam int CYC_LIMIT = 20000;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [11:0] regAddr = 12'h000;
  logic [7:0] regWdata = 8'h00;
  logic [7:0] regRdata;
  logic lockDetect = 1'b0;
  logic [6:0] bandCompare = 7'h00;
  logic [3:0] pumpCurrentCode;
  logic [7:0] bleedCurrentCode;
  logic bleedEnable;
  logic refBufferModeSel;
  logic [1:0] lockWindowBias;
  logic [1:0] lockWindowPrecision;
  logic calBusy;
  logic [6:0] bandTrial;
  logic multiplexedOutputPin;
  int errorCnt = 0;
  int nCompared = 0;
  int cycCnt = 0;
  int seed = 74;
  logic [7:0] regModel [int];
  logic [6:0] bandModel = 7'h00;

  pvc_top dut_u (
    .ref_clk(ref_clk), .rst_b(rst_b), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
    .lockDetect(lockDetect), .bandCompare(bandCompare),
    .pumpCurrentCode(pumpCurrentCode), .bleedCurrentCode(bleedCurrentCode),
    .bleedEnable(bleedEnable), .refBufferModeSel(refBufferModeSel),
    .lockWindowBias(lockWindowBias), .lockWindowPrecision(lockWindowPrecision),
    .calBusy(calBusy), .bandTrial(bandTrial), .multiplexedOutputPin(multiplexedOutputPin)
  );

  initial begin
    forever #20 ref_clk = ~ref_clk;
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  function automatic logic [7:0] m(input logic [11:0] a);
    return regModel[a];
  endfunction

  task automatic regWr(input logic [11:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    regWrite = 1'b1;
    regAddr = a;
    regWdata = d;
    @(negedge ref_clk);
    regWrite = 1'b0;
    if (regModel.exists(a)) regModel[a] = d;
  endtask

  task automatic regChk(input logic [11:0] a);
    logic [7:0] exp;
    logic [7:0] got;
    exp = regModel.exists(a) ? regModel[a] : 8'h00;
    if (a == pvc_pkg::ADDR_LOCK_STAT) exp = {7'h00, lockDetect};
    if (a == pvc_pkg::ADDR_BAND_RB) exp = {bandModel, 1'b0};
    @(negedge ref_clk);
    regRead = 1'b1;
    regAddr = a;
    @(negedge ref_clk);
    regRead = 1'b0;
    got = regRdata;
    `CHK($sformatf("read %h", a), exp, got)
  endtask

  task automatic nearChk(input string nm, input int exp, input int got);
    `CHK(nm, exp, ((got >= exp - 3) && (got <= exp + 3)) ? exp : got)
  endtask

  // Start a calibration, optionally rewrite mid-settle, and time both phases
  task automatic calRun(input bit abort);
    int n;
    int settle;
    int div;
    logic [3:0] pump;
    settle = 1024 * int'(m(pvc_pkg::ADDR_TO_COARSE) & 8'h1f) + int'(m(pvc_pkg::ADDR_TO_FINE_LO))
      + 256 * int'(m(pvc_pkg::ADDR_TO_FINE_HI) & 8'h03);
    div = int'(m(pvc_pkg::ADDR_BAND_DIV));
    pump = m(pvc_pkg::ADDR_PUMP_CODE) & 8'h0f;
    `CHK("pumpCurrentCode held", 1'b1, pumpCurrentCode !== pump)
    regWr(pvc_pkg::ADDR_INT_LOW, 8'h5a);
    `CHK("calBusy", 1'b1, calBusy)
    `CHK("pumpCurrentCode", pump, pumpCurrentCode)
    if (abort) begin
      repeat (100) @(negedge ref_clk);
      regWr(pvc_pkg::ADDR_INT_LOW, 8'h5a);
    end
    n = 0;
    while (bandTrial !== 7'h40 && n < 5000) begin
      @(negedge ref_clk);
      n++;
    end
    nearChk("settle cycles", settle + 1, n);
    n = 0;
    while (calBusy === 1'b1 && n < 5000) begin
      @(negedge ref_clk);
      n++;
    end
    nearChk("band and loop cycles", 11 * 16 * div + 256, n);
    bandModel = bandCompare;
    regChk(pvc_pkg::ADDR_BAND_RB);
  endtask

  task automatic endSim();
    $display("Comparisons %0d, mismatches %0d", nCompared, errorCnt);
    if (errorCnt == 0 && nCompared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycCnt <= cycCnt + 1;
    if (cycCnt == CYC_LIMIT) begin
      errorCnt++;
      endSim();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    regModel[pvc_pkg::ADDR_MUX_EN] = pvc_pkg::RST_MUX_EN;
    regModel[pvc_pkg::ADDR_REF_MODE] = pvc_pkg::RST_REF_MODE;
    regModel[pvc_pkg::ADDR_LOCK_WIN] = pvc_pkg::RST_LOCK_WIN;
    regModel[pvc_pkg::ADDR_TO_COARSE] = pvc_pkg::RST_TO_COARSE;
    regModel[pvc_pkg::ADDR_TO_FINE_LO] = pvc_pkg::RST_TO_FINE_LO;
    regModel[pvc_pkg::ADDR_TO_FINE_HI] = pvc_pkg::RST_TO_FINE_HI;
    regModel[pvc_pkg::ADDR_BAND_DIV] = pvc_pkg::RST_BAND_DIV;
    regModel[pvc_pkg::ADDR_BLEED_CTL] = pvc_pkg::RST_BLEED_CTL;
    regModel[pvc_pkg::ADDR_PUMP_CODE] = pvc_pkg::RST_PUMP_CODE;
    regModel[pvc_pkg::ADDR_BLEED_CODE] = pvc_pkg::RST_BLEED_CODE;
    regModel[pvc_pkg::ADDR_MUX_OUTPUT_SELECT] = pvc_pkg::RST_MUX_OUTPUT_SELECT;
    repeat (10) @(negedge ref_clk);
    rst_b = 1'b1;
    `CHK("pumpCurrentCode", 4'h4, pumpCurrentCode)
    `CHK("bleedCurrentCode", 8'h04, bleedCurrentCode)
    `CHK("calBusy", 1'b0, calBusy)
    foreach (regModel[k]) regChk(k[11:0]);
    regChk(12'h300);
    regChk(pvc_pkg::ADDR_LOCK_STAT);
    foreach (regModel[k]) begin
      regWr(k[11:0], 8'($random(seed)));
      regChk(k[11:0]);
    end
    `CHK("refBufferModeSel", m(pvc_pkg::ADDR_REF_MODE) >> 1 & 8'h01, refBufferModeSel)
    `CHK("bleedEnable", m(pvc_pkg::ADDR_BLEED_CTL) & 8'h01, bleedEnable)
    `CHK("bleedCurrentCode", m(pvc_pkg::ADDR_BLEED_CODE), bleedCurrentCode)
    `CHK("lockWindowBias", m(pvc_pkg::ADDR_LOCK_WIN) & 8'h03, lockWindowBias)
    `CHK("lockWindowPrecision", m(pvc_pkg::ADDR_LOCK_WIN) >> 2 & 8'h03, lockWindowPrecision)
    `CHK("pumpCurrentCode held", 4'h4, pumpCurrentCode)
    regWr(pvc_pkg::ADDR_BAND_RB, 8'hff);
    regWr(pvc_pkg::ADDR_LOCK_STAT, 8'hff);
    regChk(pvc_pkg::ADDR_BAND_RB);
    lockDetect = 1'b1;
    regChk(pvc_pkg::ADDR_LOCK_STAT);
    // Pin follows lock only with enable set and selector exactly one
    for (int i = 0; i < 4; i++) begin
      regWr(pvc_pkg::ADDR_MUX_EN, (i == 2) ? 8'h7f : 8'h80);
      regWr(pvc_pkg::ADDR_MUX_OUTPUT_SELECT, (i == 1) ? 8'h02 : ((i == 3) ? 8'h81 : 8'h01));
      for (int j = 0; j < 2; j++) begin
        @(negedge ref_clk);
        lockDetect = j[0];
        `CHK("pin before edge", (i == 0) & ~j[0], multiplexedOutputPin)
        @(negedge ref_clk);
        `CHK("pin after edge", (i == 0) & j[0], multiplexedOutputPin)
      end
    end
    // Settle above 30 us and band clock below 2.4 MHz at 25 MHz
    regWr(pvc_pkg::ADDR_TO_COARSE, 8'h02);
    regWr(pvc_pkg::ADDR_TO_FINE_LO, 8'h03);
    regWr(pvc_pkg::ADDR_TO_FINE_HI, 8'h00);
    regWr(pvc_pkg::ADDR_BAND_DIV, 8'h0b);
    regWr(pvc_pkg::ADDR_PUMP_CODE, 8'h09);
    bandCompare = 7'($random(seed));
    if (bandCompare == 7'h40) bandCompare = 7'h15;
    calRun(1'b0);
    regWr(pvc_pkg::ADDR_TO_FINE_LO, 8'hff);
    regWr(pvc_pkg::ADDR_TO_FINE_HI, 8'h01);
    regWr(pvc_pkg::ADDR_BAND_DIV, 8'h0c);
    regWr(pvc_pkg::ADDR_PUMP_CODE, 8'h0e);
    bandCompare = 7'($random(seed)) | 7'h01;
    calRun(1'b1);
    endSim();
  end
endmodule
